//--- rtl/sps_pkg.sv
// constants, pin indices, coil patterns and state layout of the phase sequencer
// assumes a single 250 MHz clock and pin inputs that are asynchronous to it
package sps_pkg;

  // positions of the pin inputs inside the synchroniser vectors
  localparam int NUM_IN  = 8;
  localparam int IN_STEP = 0;
  localparam int IN_EXC  = 1;
  localparam int IN_EDGE = 2;
  localparam int IN_DIR  = 3;
  localparam int IN_SRST = 4;
  localparam int IN_EN   = 5;
  localparam int IN_OC   = 6;
  localparam int IN_OT   = 7;

  localparam logic [NUM_IN-1:0] PINS_RESET = 8'h00;

  // eight half-step positions; even ones energise two coils, odd ones a single coil
  typedef logic [2:0] sps_pos_t;

  localparam sps_pos_t POS_INIT  = 3'h0;
  localparam sps_pos_t STEP_HALF = 3'h1;
  localparam sps_pos_t STEP_FULL = 3'h2;

  typedef struct packed {
    logic one_drive;
    logic one_return;
    logic two_drive;
    logic two_return;
  } sps_coils_t;

  localparam sps_coils_t COILS_OFF = 4'h0;

  // nibble per position, position 0 in the low nibble:
  // 0 drive1+ret2, 1 drive1, 2 drive1+drive2, 3 drive2,
  // 4 drive2+ret1, 5 ret1, 6 ret1+ret2, 7 ret2
  localparam logic [31:0] PATTERN_TABLE = 32'h1546_2a89;
  localparam int          PATTERN_W     = 4;

  localparam logic FAULT_KIND_OVERCURRENT = 1'b0;
  localparam logic FAULT_KIND_OVERHEAT    = 1'b1;

  typedef enum logic {
    SEQ_HOLD,
    SEQ_RUN
  } sps_seq_t;

  typedef struct packed {
    logic [NUM_IN-1:0] sync1;
    logic [NUM_IN-1:0] sync2;
    logic [NUM_IN-1:0] sync3;
    logic [NUM_IN-1:0] filt;
    sps_seq_t          seq;
    sps_pos_t          pos;
    logic              oc;
    logic              ot;
    logic              kind;
    sps_coils_t        coils;
    logic              fault_n;
  } sps_state_t;

endpackage : sps_pkg

//--- rtl/sps_stepper_phase_sequencer.sv
// phase sequencer of a unipolar two-phase stepping motor driver
// assumes every pin input is asynchronous to clock_i and far slower than it
`timescale 1ns/10ps

module sps_stepper_phase_sequencer (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic step_clock_i,
  input  wire logic excitation_select_i,
  input  wire logic edge_select_i,
  input  wire logic direction_select_i,
  input  wire logic sequencer_reset_n_i,
  input  wire logic output_enable_i,
  input  wire logic overcurrent_detect_i,
  input  wire logic overheat_detect_i,
  output logic      coil_one_drive_o,
  output logic      coil_one_return_o,
  output logic      coil_two_drive_o,
  output logic      coil_two_return_o,
  output logic      fault_flag_n_o,
  output logic      fault_kind_level_o
);

  sps_pkg::sps_state_t q;
  sps_pkg::sps_state_t d;
  logic [sps_pkg::NUM_IN-1:0] pins;
  logic [sps_pkg::NUM_IN-1:0] rise;
  logic [sps_pkg::NUM_IN-1:0] fall;
  logic                       step_edge;
  logic                       advance;
  logic                       fault_any;
  sps_pkg::sps_pos_t          incr;

  always_comb
  begin
    pins                       = '0;
    pins[sps_pkg::IN_STEP]     = step_clock_i;
    pins[sps_pkg::IN_EXC]      = excitation_select_i;
    pins[sps_pkg::IN_EDGE]     = edge_select_i;
    pins[sps_pkg::IN_DIR]      = direction_select_i;
    pins[sps_pkg::IN_SRST]     = sequencer_reset_n_i;
    pins[sps_pkg::IN_EN]       = output_enable_i;
    pins[sps_pkg::IN_OC]       = overcurrent_detect_i;
    pins[sps_pkg::IN_OT]       = overheat_detect_i;
  end

  always_comb
  begin
    d       = q;
    d.sync1 = pins;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    // a level is taken only once the second and third stages agree, which rejects
    // a single sample caught mid-transition
    d.filt  = (q.sync2 & q.sync3) | (q.filt & (q.sync2 ^ q.sync3));
    rise    = d.filt & ~q.filt;
    fall    = ~d.filt & q.filt;

    step_edge = rise[sps_pkg::IN_STEP]
              | (~q.filt[sps_pkg::IN_EDGE] & fall[sps_pkg::IN_STEP]);

    // fault latches: a detector firing in the clearing cycle keeps its latch set
    d.oc = q.filt[sps_pkg::IN_OC] | (q.oc & ~rise[sps_pkg::IN_SRST]);
    d.ot = q.filt[sps_pkg::IN_OT] | (q.ot & ~rise[sps_pkg::IN_SRST]);
    if (q.filt[sps_pkg::IN_OT] && !q.ot)
    begin
      d.kind = sps_pkg::FAULT_KIND_OVERHEAT;
    end
    else if (q.filt[sps_pkg::IN_OC] && !q.oc && !q.ot)
    begin
      d.kind = sps_pkg::FAULT_KIND_OVERCURRENT;
    end
    fault_any = d.oc | d.ot;

    // stepping pauses while disabled or faulted so the position is kept
    advance = step_edge && q.filt[sps_pkg::IN_EN] && !(q.oc | q.ot);
    // an odd position in full-step mode takes a half step back onto the
    // two-coil grid, so a mode change never skips a phase
    incr = (q.filt[sps_pkg::IN_EXC] || q.pos[0]) ? sps_pkg::STEP_HALF
                                                 : sps_pkg::STEP_FULL;

    case (q.seq)
      sps_pkg::SEQ_HOLD:
      begin
        d.pos = sps_pkg::POS_INIT;
        if (rise[sps_pkg::IN_SRST])
        begin
          d.seq = sps_pkg::SEQ_RUN;
        end
      end
      sps_pkg::SEQ_RUN:
      begin
        if (!q.filt[sps_pkg::IN_SRST])
        begin
          d.seq = sps_pkg::SEQ_HOLD;
          d.pos = sps_pkg::POS_INIT;
        end
        else if (advance)
        begin
          d.pos = q.filt[sps_pkg::IN_DIR] ? q.pos - incr : q.pos + incr;
        end
      end
      default:
      begin
        d.seq = sps_pkg::SEQ_HOLD;
        d.pos = sps_pkg::POS_INIT;
      end
    endcase

    if (d.seq == sps_pkg::SEQ_RUN && d.filt[sps_pkg::IN_EN] && !fault_any)
    begin
      d.coils = sps_pkg::PATTERN_TABLE[d.pos*sps_pkg::PATTERN_W +: sps_pkg::PATTERN_W];
    end
    else
    begin
      d.coils = sps_pkg::COILS_OFF;
    end
    d.fault_n = ~fault_any;
  end

  // the synchronous reset stands in for the power-on reset of the logic supply
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      q.sync1   <= sps_pkg::PINS_RESET;
      q.sync2   <= sps_pkg::PINS_RESET;
      q.sync3   <= sps_pkg::PINS_RESET;
      q.filt    <= sps_pkg::PINS_RESET;
      q.seq     <= sps_pkg::SEQ_HOLD;
      q.pos     <= sps_pkg::POS_INIT;
      q.oc      <= 1'b0;
      q.ot      <= 1'b0;
      q.kind    <= sps_pkg::FAULT_KIND_OVERCURRENT;
      q.coils   <= sps_pkg::COILS_OFF;
      q.fault_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign coil_one_drive_o   = q.coils.one_drive;
  assign coil_one_return_o  = q.coils.one_return;
  assign coil_two_drive_o   = q.coils.two_drive;
  assign coil_two_return_o  = q.coils.two_return;
  assign fault_flag_n_o     = q.fault_n;
  assign fault_kind_level_o = q.kind;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_step_needs_edge: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && !step_edge)
    |=> q.pos == $past(q.pos))
    else $error("position moved without a qualifying step edge");

  a_full_step_fwd: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && advance
     && !q.filt[sps_pkg::IN_EXC] && !q.filt[sps_pkg::IN_DIR] && !q.pos[0])
    |=> q.pos == $past(q.pos) + sps_pkg::STEP_FULL)
    else $error("full-step forward did not advance two positions");

  a_half_step_rev: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && advance
     && q.filt[sps_pkg::IN_EXC] && q.filt[sps_pkg::IN_DIR])
    |=> q.pos == $past(q.pos) - sps_pkg::STEP_HALF)
    else $error("half-step reverse did not go back one position");

  // the release cycle itself already loads the start state, so it is left out here
  a_reset_holds_off: assert property (
    (!q.filt[sps_pkg::IN_SRST] && !rise[sps_pkg::IN_SRST])
    |=> q.seq == sps_pkg::SEQ_HOLD && q.coils == sps_pkg::COILS_OFF)
    else $error("sequencer ran or drove coils while held in reset");

  a_release_init: assert property (
    (q.seq == sps_pkg::SEQ_HOLD && rise[sps_pkg::IN_SRST] && d.filt[sps_pkg::IN_EN] && !fault_any)
    |=> q.coils == sps_pkg::PATTERN_TABLE[sps_pkg::PATTERN_W-1:0])
    else $error("reset release did not energise drive one and return two");

  // coils follow the filtered enable in the cycle it rises, hence the rise term
  a_disable_off: assert property (
    (!q.filt[sps_pkg::IN_EN] && !rise[sps_pkg::IN_EN]) |=> q.coils == sps_pkg::COILS_OFF)
    else $error("coils driven while output enable low");

  a_disable_keeps: assert property (
    (!q.filt[sps_pkg::IN_EN] && q.filt[sps_pkg::IN_SRST] && q.seq == sps_pkg::SEQ_RUN)
    |=> $stable(q.pos))
    else $error("position changed while outputs disabled");

  a_fault_flag: assert property (
    (q.filt[sps_pkg::IN_OC] || q.filt[sps_pkg::IN_OT]) |=> !fault_flag_n_o)
    else $error("fault flag not low after a detector fired");

  a_kind_heat: assert property (
    (q.filt[sps_pkg::IN_OT] && !q.ot) |=> fault_kind_level_o == sps_pkg::FAULT_KIND_OVERHEAT)
    else $error("fault kind does not show overheat");

  a_fault_latched: assert property (
    (!fault_flag_n_o && !rise[sps_pkg::IN_SRST])
    |=> !fault_flag_n_o && q.coils == sps_pkg::COILS_OFF)
    else $error("fault latch dropped or coils driven without a reset pulse");

  a_full_from_odd: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && advance
     && !q.filt[sps_pkg::IN_EXC] && q.pos[0])
    |=> !q.pos[0])
    else $error("full-step from a single-coil position left the two-coil grid");

  a_full_step_rev: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && advance
     && !q.filt[sps_pkg::IN_EXC] && q.filt[sps_pkg::IN_DIR] && !q.pos[0])
    |=> q.pos == $past(q.pos) - sps_pkg::STEP_FULL)
    else $error("full-step reverse did not go back two positions");

  a_half_step_fwd: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && advance
     && q.filt[sps_pkg::IN_EXC] && !q.filt[sps_pkg::IN_DIR])
    |=> q.pos == $past(q.pos) + sps_pkg::STEP_HALF)
    else $error("half-step forward did not advance one position");

  a_rev_from_odd: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && advance
     && !q.filt[sps_pkg::IN_EXC] && q.filt[sps_pkg::IN_DIR] && q.pos[0])
    |=> q.pos == $past(q.pos) - sps_pkg::STEP_HALF)
    else $error("full-step reverse from a single-coil position skipped a phase");

  a_rise_only: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && q.filt[sps_pkg::IN_EDGE]
     && fall[sps_pkg::IN_STEP])
    |=> $stable(q.pos))
    else $error("falling step edge moved the position in rising-edge mode");

  a_both_edges: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && q.filt[sps_pkg::IN_EN]
     && !(q.oc || q.ot) && !q.filt[sps_pkg::IN_EDGE] && fall[sps_pkg::IN_STEP])
    |=> q.pos != $past(q.pos))
    else $error("falling step edge ignored in both-edge mode");

  a_fault_release: assert property (
    (rise[sps_pkg::IN_SRST] && !q.filt[sps_pkg::IN_OC] && !q.filt[sps_pkg::IN_OT])
    |=> fault_flag_n_o)
    else $error("sequencer reset pulse did not clear the fault flag");

  a_kind_current: assert property (
    (q.filt[sps_pkg::IN_OC] && !q.filt[sps_pkg::IN_OT] && !q.oc && !q.ot)
    |=> fault_kind_level_o == sps_pkg::FAULT_KIND_OVERCURRENT)
    else $error("fault kind does not show overcurrent");

  a_kind_heat_held: assert property (
    q.ot |-> fault_kind_level_o == sps_pkg::FAULT_KIND_OVERHEAT)
    else $error("a later overcurrent overwrote the overheat kind");

  a_winding_count: assert property (
    (q.coils != sps_pkg::COILS_OFF)
    |-> $countones(q.coils) == (q.pos[0] ? 1 : 2))
    else $error("energised winding count does not match the position parity");

  a_coil_exclusive: assert property (
    !(q.coils.one_drive && q.coils.one_return)
    && !(q.coils.two_drive && q.coils.two_return))
    else $error("both windings of one coil energised together");

  a_fault_coils_off: assert property (
    (q.oc || q.ot) |-> q.coils == sps_pkg::COILS_OFF)
    else $error("coils driven while a fault is latched");

  a_fault_frozen: assert property (
    ((q.oc || q.ot) && q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST])
    |=> $stable(q.pos))
    else $error("position moved while a fault is latched");

  a_hold_at_init: assert property (
    q.seq == sps_pkg::SEQ_HOLD |-> q.pos == sps_pkg::POS_INIT)
    else $error("held sequencer left the start position");

  a_enable_resume: assert property (
    (q.seq == sps_pkg::SEQ_RUN && q.filt[sps_pkg::IN_SRST] && rise[sps_pkg::IN_EN]
     && !fault_any)
    |=> q.coils != sps_pkg::COILS_OFF && q.pos == $past(q.pos))
    else $error("re-enable did not resume at the held position");

  c_full_cycle: cover property (
    advance && !q.filt[sps_pkg::IN_EXC] ##[1:1000] advance ##[1:1000] advance ##[1:1000] advance);
  c_half_reverse: cover property (advance && q.filt[sps_pkg::IN_EXC] && q.filt[sps_pkg::IN_DIR]);
  c_fault_clear: cover property (!fault_flag_n_o ##[1:1000] fault_flag_n_o);
  c_enable_pause: cover property (!q.filt[sps_pkg::IN_EN] ##[1:1000] q.filt[sps_pkg::IN_EN]);

endmodule : sps_stepper_phase_sequencer

//--- sim/sps_ctrl_model.sv
// motion controller model: one step clock level change per request
// assumes requests arrive only while ready_o is high
`timescale 1ns/10ps

module sps_ctrl_model (
  input  wire logic clock_i,
  input  wire logic toggle_i,
  output logic      step_clock_o,
  output logic      ready_o
);
  int unsigned hold_q = 0;

  initial
  begin
    step_clock_o = 1'b0;
    ready_o      = 1'b1;
  end

  // each level is held at least 6 clocks so the synchroniser always sees it
  always @(posedge clock_i)
  begin
    if (hold_q != 0)
      hold_q <= hold_q - 1;
    else if (!ready_o)
      ready_o <= 1'b1;
    else if (toggle_i)
    begin
      step_clock_o <= ~step_clock_o;
      ready_o      <= 1'b0;
      hold_q       <= 4 + $urandom_range(0, 6);
    end
  end
endmodule : sps_ctrl_model

//--- sim/stepper_phase_sequencer_tb.sv
// self-checking bench: drivers queue expected outputs, a monitor compares on change
// assumes the pin latency of four clocks and a 250 MHz clock
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

module stepper_phase_sequencer_tb;
  logic clock_i = 1'b0, resetn_i = 1'b0, exc = 1'b0, edg = 1'b1, dir = 1'b0;
  logic srst_n = 1'b1, en = 1'b0, oc = 1'b0, ot = 1'b0, tog = 1'b0, step, rdy;
  logic c1d, c1r, c2d, c2r, flag_n, kind;
  logic [5:0] exp_q[$];
  logic [5:0] last_q = 6'h02, seen, ex;
  logic [3:0] pat [8] = '{4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
  int         err_count = 0, check_count = 0, pos = 0, n;
  logic       flt = 1'b0;

  sps_ctrl_model CTRL (.clock_i(clock_i), .toggle_i(tog), .step_clock_o(step), .ready_o(rdy));

  sps_stepper_phase_sequencer DUT (
    .clock_i(clock_i), .resetn_i(resetn_i), .step_clock_i(step), .excitation_select_i(exc),
    .edge_select_i(edg), .direction_select_i(dir), .sequencer_reset_n_i(srst_n),
    .output_enable_i(en), .overcurrent_detect_i(oc), .overheat_detect_i(ot),
    .coil_one_drive_o(c1d), .coil_one_return_o(c1r), .coil_two_drive_o(c2d),
    .coil_two_return_o(c2r), .fault_flag_n_o(flag_n), .fault_kind_level_o(kind));

  initial
  begin
    forever #2 clock_i = ~clock_i;
  end

  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic tick(int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : tick

  // one step clock level change; a note is queued only when it must move the coils
  task automatic toggle();
    int w;
    if ((!step || !edg) && en && !flt)
    begin
      if (exc || pos % 2)
        pos = (pos + (dir ? 7 : 1)) % 8;
      else
        pos = (pos + (dir ? 6 : 2)) % 8;
      exp_q.push_back({pat[pos], 2'b10});
    end
    tog = 1'b1;
    tick(1);
    tog = 1'b0;
    for (w = 0; w < 40 && !rdy; w++) tick(1);
    tick(2);
  endtask : toggle

  task automatic seq_pulse();
    srst_n = 1'b0;
    tick(8);
    srst_n = 1'b1;
    pos = 0;
    flt = 1'b0;
    exp_q.push_back({pat[0], 2'b10});
    tick(10);
  endtask : seq_pulse

  always @(negedge clock_i)
  begin
    seen = {c1d, c1r, c2d, c2r, flag_n, kind};
    if (resetn_i && seen !== last_q)
    begin
      last_q = seen;
      ex = (exp_q.size() != 0) ? exp_q.pop_front() : 6'h3f;
      if (ex[1]) seen[0] = ex[0];
      `CHK("coils_fault", ex, seen)
    end
  end

  initial
  begin
    #300us;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'hdb34));
    exp_q.push_back({pat[0], 2'b10});
    tick(8);
    resetn_i = 1'b1;
    en = 1'b1;
    tick(12);
    for (int m = 0; m < 16; m++)
    begin
      {dir, edg, exc} = m[2:0];
      tick(6);
      n = 1 + $urandom_range(0, 4);
      repeat (n) toggle();
    end
    en = 1'b0;
    exp_q.push_back(6'h02);
    tick(6);
    repeat (3) toggle();
    en = 1'b1;
    exp_q.push_back({pat[pos], 2'b10});
    tick(8);
    exp_q.push_back(6'h02);
    seq_pulse();
    for (int k = 0; k < 2; k++)
    begin
      repeat (3) toggle();
      {ot, oc} = k ? 2'b10 : 2'b01;
      flt = 1'b1;
      exp_q.push_back({4'h0, 1'b0, k[0]});
      tick(8);
      repeat (2) toggle();
      {ot, oc} = 2'b00;
      tick(8);
      seq_pulse();
    end
    for (n = 0; n < 100 && exp_q.size() != 0; n++) tick(1);
    `CHK("queue_left", 0, exp_q.size())
    report_and_stop();
  end
endmodule : stepper_phase_sequencer_tb
